// *** shared/uart_pkg.sv ***
package uart_pkg;

	localparam int          ADDR_W = 18;
	localparam logic [15:0] IDX_STATUS  = 16'h4100;
	localparam logic [15:0] IDX_TXDATA  = 16'h4101;
	localparam logic [15:0] IDX_RXDATA  = 16'h4102;
	localparam logic [15:0] IDX_FORMAT  = 16'h4103;
	localparam logic [15:0] IDX_CONTROL = 16'h4104;

	// channel_status bit positions
	localparam int ST_DONE    = 7;
	localparam int ST_FRAME   = 6;
	localparam int ST_PARITY  = 5;
	localparam int ST_OVERRUN = 4;
	localparam int ST_SECOND  = 3;
	localparam int ST_BUSY    = 2;
	localparam int ST_READY   = 1;
	localparam int ST_TBE     = 0;

	// character_format and channel_control bit positions
	localparam int FMT_LEN    = 4;
	localparam int FMT_PEN    = 3;
	localparam int FMT_ODD    = 2;
	localparam int FMT_STOP   = 1;
	localparam int CTL_THRESH = 1;
	localparam int CTL_EN     = 0;

	localparam logic [7:0] FORMAT_MASK   = 8'h1E;
	localparam logic [7:0] CONTROL_MASK  = 8'h03;
	localparam logic [7:0] STATUS_RESET  = 8'h01;
	localparam logic [7:0] TXDATA_RESET  = 8'h00;
	localparam logic [7:0] RXDATA_RESET  = 8'h00;
	localparam logic [7:0] FORMAT_RESET  = 8'h00;
	localparam logic [7:0] CONTROL_RESET = 8'h00;

	localparam int CLK_HZ     = 20_000_000;
	localparam int BAUD_BPS   = 115_200;
	localparam int BIT_CYCLES = CLK_HZ / BAUD_BPS;

	typedef enum logic [2:0] {
		SEL_NONE    = 3'b000,
		SEL_STATUS  = 3'b001,
		SEL_TXDATA  = 3'b010,
		SEL_RXDATA  = 3'b011,
		SEL_FORMAT  = 3'b100,
		SEL_CONTROL = 3'b101
	} reg_sel_t;

	typedef enum logic [2:0] {
		LN_IDLE  = 3'b000,
		LN_START = 3'b001,
		LN_DATA  = 3'b010,
		LN_PAR   = 3'b011,
		LN_STOP  = 3'b100
	} line_state_t;

endpackage

// *** hw/uart_tx_shift.sv ***
`timescale 1ns/1ps
module uart_tx_shift #(
	parameter int BIT_CYCLES = uart_pkg::BIT_CYCLES
) (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       load,
	input  wire logic [7:0] data,
	input  wire logic       len8,
	input  wire logic       par_en,
	input  wire logic       par_odd,
	input  wire logic       two_stop,
	output logic            serial_out,
	output logic            busy,
	output logic            done
);
	localparam int CW = $clog2(BIT_CYCLES + 1);
	typedef struct packed {
		uart_pkg::line_state_t st;
		logic [CW-1:0]         cnt;
		logic [2:0]            bitn;
		logic [7:0]            shreg;
		logic                  par;
		logic                  stops;
		logic                  serial;
		logic                  busy;
		logic                  done;
	} tx_t;
	tx_t s, next_s;
	logic tick;
	logic [7:0] masked;

	assign tick       = s.cnt == CW'(BIT_CYCLES - 1);
	assign masked     = len8 ? data : {1'b0, data[6:0]};
	assign serial_out = s.serial;
	assign busy       = s.busy;
	assign done       = s.done;

	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		if (s.st != uart_pkg::LN_IDLE)
			next_s.cnt = tick ? '0 : s.cnt + 1'b1;
		unique case (s.st)
			uart_pkg::LN_IDLE: if (load) begin
				next_s.st     = uart_pkg::LN_START;
				next_s.shreg  = masked;
				next_s.par    = ^masked ^ par_odd;
				next_s.bitn   = '0;
				next_s.cnt    = '0;
				next_s.serial = 1'b0;
				next_s.busy   = 1'b1;
			end
			uart_pkg::LN_START: if (tick) begin
				next_s.st     = uart_pkg::LN_DATA;
				next_s.serial = s.shreg[0];
			end
			uart_pkg::LN_DATA: if (tick) begin
				next_s.shreg = s.shreg >> 1;
				next_s.bitn  = s.bitn + 1'b1;
				next_s.stops = two_stop;
				if (s.bitn == (len8 ? 3'd7 : 3'd6)) begin
					next_s.st     = par_en ? uart_pkg::LN_PAR : uart_pkg::LN_STOP;
					next_s.serial = par_en ? s.par : 1'b1;
				end else begin
					next_s.serial = s.shreg[1];
				end
			end
			uart_pkg::LN_PAR: if (tick) begin
				next_s.st     = uart_pkg::LN_STOP;
				next_s.serial = 1'b1;
			end
			uart_pkg::LN_STOP: if (tick) begin
				if (s.stops) begin
					next_s.stops = 1'b0;
				end else begin
					next_s.st   = uart_pkg::LN_IDLE;
					next_s.busy = 1'b0;
					next_s.done = 1'b1;
				end
			end
			default: next_s.st = uart_pkg::LN_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s        <= '0;
			s.serial <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	start_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
		load && s.st == uart_pkg::LN_IDLE |=> !serial_out && busy)
		else $error("start bit not driven low on load");
endmodule

// *** hw/uart_rx_shift.sv ***
`timescale 1ns/1ps
module uart_rx_shift #(
	parameter int BIT_CYCLES = uart_pkg::BIT_CYCLES
) (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       enable,
	input  wire logic       serial_in,
	input  wire logic       len8,
	input  wire logic       par_en,
	input  wire logic       par_odd,
	output logic            valid,
	output logic [7:0]      data,
	output logic            frame_err,
	output logic            parity_err
);
	localparam int CW = $clog2(BIT_CYCLES + 1);
	typedef struct packed {
		uart_pkg::line_state_t st;
		logic [CW-1:0]         cnt;
		logic [2:0]            bitn;
		logic [7:0]            shreg;
		logic                  pbit;
		logic                  valid;
		logic [7:0]            data;
		logic                  ferr;
		logic                  perr;
	} rx_t;
	rx_t s, next_s;
	logic tick;

	assign tick       = s.cnt == CW'(BIT_CYCLES - 1);
	assign valid      = s.valid;
	assign data       = s.data;
	assign frame_err  = s.ferr;
	assign parity_err = s.perr;

	always_comb begin
		next_s = s;
		next_s.valid = 1'b0;
		next_s.cnt = tick ? '0 : s.cnt + 1'b1;
		unique case (s.st)
			uart_pkg::LN_IDLE: begin
				next_s.cnt = '0;
				if (!serial_in) begin
					next_s.st    = uart_pkg::LN_START;
					next_s.shreg = '0;
					next_s.bitn  = '0;
				end
			end
			// half a bit later the start bit must still be low, else it was a glitch
			uart_pkg::LN_START: if (s.cnt == CW'(BIT_CYCLES / 2)) begin
				next_s.cnt = '0;
				next_s.st  = serial_in ? uart_pkg::LN_IDLE : uart_pkg::LN_DATA;
			end
			uart_pkg::LN_DATA: if (tick) begin
				next_s.shreg[s.bitn] = serial_in;
				next_s.bitn = s.bitn + 1'b1;
				if (s.bitn == (len8 ? 3'd7 : 3'd6))
					next_s.st = par_en ? uart_pkg::LN_PAR : uart_pkg::LN_STOP;
			end
			uart_pkg::LN_PAR: if (tick) begin
				next_s.pbit = serial_in;
				next_s.st   = uart_pkg::LN_STOP;
			end
			uart_pkg::LN_STOP: if (tick) begin
				next_s.st    = uart_pkg::LN_IDLE;
				next_s.valid = 1'b1;
				next_s.data  = s.shreg;
				next_s.ferr  = !serial_in;
				next_s.perr  = par_en && (s.pbit != (^s.shreg ^ par_odd));
			end
			default: next_s.st = uart_pkg::LN_IDLE;
		endcase
		// a disabled receiver delivers nothing, even a frame ending this cycle
		if (!enable) begin
			next_s.st    = uart_pkg::LN_IDLE;
			next_s.valid = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			s <= '0;
		else
			s <= next_s;
	end

	seven_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
		valid && !len8 |-> data[7] == 1'b0)
		else $error("bit 7 set in 7-bit character");
endmodule

// *** hw/uart_channel.sv ***
// What this block does
// - transmit done flag sets when busy falls
// - writing one clears done and error flags
// - stop bit low sets framing error
// - parity checked on move into buffer
// - full buffer: overrun flag, buffer kept
// - second flag sets, clears on read
// - busy from shift load until done
// - ready flag until buffer fully read
// - buffer-empty resets high, tracks transmit data
// - data write starts transmit, stays readable
// - buffer-to-shifter move raises empty cause
// - 7-bit: ignore tx bit7, rx bit7 zero
// - transmit least significant bit first
// - receive first bit as least significant
// - two-entry receive FIFO, oldest first
// - full cause at one or two characters
// - length bit: 1 eight, 0 seven bits
// - parity enable adds and checks parity
// - parity mode: 1 odd, 0 even
// - stop select 1 gives two stop bits
// - one stop bit default, one start bit
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
module uart_channel #(
	parameter int BIT_CYCLES = uart_pkg::BIT_CYCLES
) (
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [uart_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire logic                        serial_in_pin,
	output logic                             serial_out_pin,
	output logic                             tx_empty_cause,
	output logic                             rx_full_cause
);
	typedef struct packed {
		logic            ready;
		logic            slverr;
		logic [7:0]      rdata;
		logic [7:0]      tdata;
		logic [7:0]      fmt;
		logic [7:0]      ctl;
		logic            tbe;
		logic            done;
		logic            ferr;
		logic            perr;
		logic            oerr;
		logic [1:0][7:0] fifo;
		logic            head;
		logic [1:0]      count;
		logic            txcause;
		logic            rxcause;
	} chan_t;
	chan_t s, next_s;

	uart_pkg::reg_sel_t sel;
	logic       setup;
	logic       access;
	logic       pop;
	logic       wr_tx;
	logic       wr_st;
	logic       load_now;
	logic       tx_busy;
	logic       tx_done;
	logic       rx_valid;
	logic [7:0] rx_data;
	logic       rx_ferr;
	logic       rx_perr;
	logic [7:0] status;

	function automatic uart_pkg::reg_sel_t decode(input logic [uart_pkg::ADDR_W-1:0] a);
		unique case (a)
			{uart_pkg::IDX_STATUS, 2'b00}:  decode = uart_pkg::SEL_STATUS;
			{uart_pkg::IDX_TXDATA, 2'b00}:  decode = uart_pkg::SEL_TXDATA;
			{uart_pkg::IDX_RXDATA, 2'b00}:  decode = uart_pkg::SEL_RXDATA;
			{uart_pkg::IDX_FORMAT, 2'b00}:  decode = uart_pkg::SEL_FORMAT;
			{uart_pkg::IDX_CONTROL, 2'b00}: decode = uart_pkg::SEL_CONTROL;
			default:                        decode = uart_pkg::SEL_NONE;
		endcase
	endfunction

	assign sel    = decode(paddr);
	assign setup  = psel && !penable;
	assign access = psel && penable && s.ready;
	assign pop    = access && !pwrite && sel == uart_pkg::SEL_RXDATA;
	assign wr_tx  = access && pwrite && sel == uart_pkg::SEL_TXDATA;
	assign wr_st  = access && pwrite && sel == uart_pkg::SEL_STATUS;

	// busy rises at the same edge as the load, so no second load can slip in
	assign load_now = s.ctl[uart_pkg::CTL_EN] && !s.tbe && !tx_busy;

	always_comb begin
		status = '0;
		status[uart_pkg::ST_DONE]    = s.done;
		status[uart_pkg::ST_FRAME]   = s.ferr;
		status[uart_pkg::ST_PARITY]  = s.perr;
		status[uart_pkg::ST_OVERRUN] = s.oerr;
		status[uart_pkg::ST_SECOND]  = s.count == 2'd2;
		status[uart_pkg::ST_BUSY]    = tx_busy;
		status[uart_pkg::ST_READY]   = s.count != 2'd0;
		status[uart_pkg::ST_TBE]     = s.tbe;
	end

	uart_tx_shift #(
		.BIT_CYCLES(BIT_CYCLES)
	) tx_shift (
		.pclk      (pclk),
		.presetn   (presetn),
		.load      (load_now),
		.data      (s.tdata),
		.len8      (s.fmt[uart_pkg::FMT_LEN]),
		.par_en    (s.fmt[uart_pkg::FMT_PEN]),
		.par_odd   (s.fmt[uart_pkg::FMT_ODD]),
		.two_stop  (s.fmt[uart_pkg::FMT_STOP]),
		.serial_out(serial_out_pin),
		.busy      (tx_busy),
		.done      (tx_done)
	);

	uart_rx_shift #(
		.BIT_CYCLES(BIT_CYCLES)
	) rx_shift (
		.pclk      (pclk),
		.presetn   (presetn),
		.enable    (s.ctl[uart_pkg::CTL_EN]),
		.serial_in (serial_in_pin),
		.len8      (s.fmt[uart_pkg::FMT_LEN]),
		.par_en    (s.fmt[uart_pkg::FMT_PEN]),
		.par_odd   (s.fmt[uart_pkg::FMT_ODD]),
		.valid     (rx_valid),
		.data      (rx_data),
		.frame_err (rx_ferr),
		.parity_err(rx_perr)
	);

	always_comb begin
		next_s = s;
		// pready answers in the first access cycle: zero wait states
		next_s.ready   = setup;
		next_s.slverr  = setup && sel == uart_pkg::SEL_NONE;
		next_s.txcause = load_now;
		next_s.rxcause = 1'b0;
		if (setup) begin
			unique case (sel)
				uart_pkg::SEL_STATUS:  next_s.rdata = status;
				uart_pkg::SEL_TXDATA:  next_s.rdata = s.tdata;
				uart_pkg::SEL_RXDATA:  next_s.rdata = s.fifo[s.head];
				uart_pkg::SEL_FORMAT:  next_s.rdata = s.fmt;
				uart_pkg::SEL_CONTROL: next_s.rdata = s.ctl;
				default:               next_s.rdata = '0;
			endcase
		end

		if (load_now)
			next_s.tbe = 1'b1;
		if (wr_tx) begin
			next_s.tdata = pwdata[7:0];
			next_s.tbe   = 1'b0;
		end
		if (access && pwrite && sel == uart_pkg::SEL_FORMAT)
			next_s.fmt = pwdata[7:0] & uart_pkg::FORMAT_MASK;
		if (access && pwrite && sel == uart_pkg::SEL_CONTROL) begin
			next_s.ctl = pwdata[7:0] & uart_pkg::CONTROL_MASK;
			// disabling drops whatever still waits in the transmit buffer
			if (!pwdata[uart_pkg::CTL_EN])
				next_s.tbe = 1'b1;
		end

		// clears first so that a same-cycle hardware set wins
		if (wr_st) begin
			if (pwdata[uart_pkg::ST_DONE])
				next_s.done = 1'b0;
			if (pwdata[uart_pkg::ST_FRAME])
				next_s.ferr = 1'b0;
			if (pwdata[uart_pkg::ST_PARITY])
				next_s.perr = 1'b0;
			if (pwdata[uart_pkg::ST_OVERRUN])
				next_s.oerr = 1'b0;
		end
		if (tx_done)
			next_s.done = 1'b1;

		if (pop && s.count != 2'd0) begin
			next_s.head  = !s.head;
			next_s.count = s.count - 2'd1;
		end
		if (rx_valid) begin
			if (rx_ferr)
				next_s.ferr = 1'b1;
			if (next_s.count == 2'd2) begin
				// the older characters stay, the new one is dropped
				next_s.oerr = 1'b1;
			end else begin
				next_s.fifo[next_s.head ^ next_s.count[0]] = rx_data;
				next_s.count = next_s.count + 2'd1;
				if (rx_perr)
					next_s.perr = 1'b1;
				next_s.rxcause = next_s.count == (s.ctl[uart_pkg::CTL_THRESH] ? 2'd2 : 2'd1);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s       <= '0;
			s.tdata <= uart_pkg::TXDATA_RESET;
			s.fmt   <= uart_pkg::FORMAT_RESET;
			s.ctl   <= uart_pkg::CONTROL_RESET;
			s.fifo  <= {2{uart_pkg::RXDATA_RESET}};
			s.tbe   <= uart_pkg::STATUS_RESET[uart_pkg::ST_TBE];
		end else begin
			s <= next_s;
		end
	end

	assign prdata         = {24'h000000, s.rdata};
	assign pready         = s.ready;
	assign pslverr        = s.slverr;
	assign tx_empty_cause = s.txcause;
	assign rx_full_cause  = s.rxcause;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	done_set_a: assert property ($fell(tx_busy) |=> s.done)
		else $error("done flag not set after busy fell");

	done_clear_a: assert property (wr_st && pwdata[7] && !tx_done |=> !s.done)
		else $error("done flag not cleared by writing one");

	zero_keeps_a: assert property (wr_st && !pwdata[6] && s.ferr |=> s.ferr)
		else $error("writing zero cleared framing flag");

	frame_set_a: assert property (rx_valid && rx_ferr |=> s.ferr)
		else $error("framing flag not set");

	parity_set_a: assert property (rx_valid && rx_perr && s.count != 2'd2 |=> s.perr)
		else $error("parity flag not set on buffered character");

	overrun_keep_a: assert property (rx_valid && s.count == 2'd2 && !pop
		|=> s.oerr && s.count == 2'd2 && $stable(s.fifo))
		else $error("overrun flag missing or buffer disturbed");

	second_pop_a: assert property (pop && s.count == 2'd2 && !rx_valid
		|=> s.count == 2'd1 && !status[3] && status[1])
		else $error("first read did not drop second flag");

	tx_load_a: assert property (load_now && !wr_tx |=> s.tbe && tx_busy ##1 tx_busy)
		else $error("load did not empty buffer and raise busy");

	tx_write_a: assert property (wr_tx |=> !s.tbe ##0 s.tdata == $past(pwdata[7:0]))
		else $error("transmit write not held in buffer");

	empty_cause_a: assert property (load_now |=> tx_empty_cause ##1 !tx_empty_cause)
		else $error("empty cause not pulsed on load");

	full_cause_a: assert property (rx_valid && s.count == 2'd0 && !pop
		&& !s.ctl[1] |=> rx_full_cause)
		else $error("full cause missing at one character");

	apb_ready_a: assert property (setup |=> pready)
		else $error("pready missing after setup");

	ready_once_a: assert property (pready |=> !pready)
		else $error("pready held too long");

	unmapped_a: assert property (setup && sel == uart_pkg::SEL_NONE
		|=> pready && pslverr && prdata == 32'h00000000)
		else $error("unmapped access not flagged");

	tx_hold_a: assert property (!wr_tx |=> $stable(s.tdata))
		else $error("transmit data changed without write");

	tx_start_a: assert property (wr_tx && s.ctl[uart_pkg::CTL_EN] && !tx_busy
		|-> ##2 tx_busy)
		else $error("transmit write did not start");

	busy_load_a: assert property ($rose(tx_busy) |-> $past(load_now))
		else $error("busy rose without load");

	busy_end_a: assert property (tx_done |-> $fell(tx_busy))
		else $error("done pulse without busy falling");

	done_src_a: assert property ($rose(s.done) |-> $past(tx_done))
		else $error("done flag set without frame end");

	done_keep_a: assert property (!wr_st && s.done |=> s.done)
		else $error("done flag lost without write");

	perr_keep_a: assert property (!wr_st && s.perr |=> s.perr)
		else $error("parity flag lost without write");

	oerr_keep_a: assert property (!wr_st && s.oerr |=> s.oerr)
		else $error("overrun flag lost without write");

	overrun_src_a: assert property ($rose(s.oerr) |-> $past(rx_valid)
		&& $past(s.count) == 2'h2 && !$past(pop))
		else $error("overrun flag without full buffer");

	frame_src_a: assert property ($rose(s.ferr)
		|-> $past(rx_valid) && $past(rx_ferr))
		else $error("framing flag without bad stop");

	parity_off_a: assert property (rx_valid && !s.fmt[uart_pkg::FMT_PEN]
		|-> !rx_perr)
		else $error("parity error with parity off");

	line_idle_a: assert property (!tx_busy |-> serial_out_pin)
		else $error("serial output not idle high");

	start_low_a: assert property ($rose(tx_busy) |-> !serial_out_pin)
		else $error("frame without start bit");

	rx_off_a: assert property (!s.ctl[uart_pkg::CTL_EN] |=> !rx_valid)
		else $error("disabled receiver delivered data");

	count_max_a: assert property (s.count != 2'h3)
		else $error("receive count beyond two");

	full_two_a: assert property (rx_valid && s.count == 2'h1 && !pop
		&& s.ctl[uart_pkg::CTL_THRESH] |=> rx_full_cause)
		else $error("full cause missing at two characters");

	cause_ready_a: assert property (rx_full_cause |-> status[uart_pkg::ST_READY])
		else $error("full cause with empty buffer");

	ready_set_a: assert property (rx_valid && s.count != 2'h2
		|=> status[uart_pkg::ST_READY])
		else $error("ready flag not set");

	ready_clr_a: assert property (pop && s.count == 2'h1 && !rx_valid
		|=> !status[uart_pkg::ST_READY])
		else $error("ready flag kept after last read");

	second_set_a: assert property (rx_valid && s.count == 2'h1 && !pop
		|=> status[uart_pkg::ST_SECOND])
		else $error("second flag not set");

	fifo_keep_a: assert property (rx_valid && s.count == 2'h1 && !pop
		|=> $stable(s.head) && $stable(s.fifo[s.head]))
		else $error("oldest character disturbed");

	pop_turn_a: assert property (pop && s.count != 2'h0
		|=> s.head != $past(s.head))
		else $error("read did not advance buffer");

	cover_overrun: cover property (rx_valid && s.count == 2'd2);
	cover_two_full: cover property (rx_valid && s.count == 2'd1 && s.ctl[1]);
	cover_tx_done: cover property (tx_done);
	cover_pop: cover property (pop && s.count == 2'd2);
	cover_rx_parity: cover property (rx_valid && rx_perr);
endmodule

// *** test/uart_remote.sv ***
`timescale 1ns/1ps
module uart_remote #(
	parameter int BC = 8
) (
	input  wire logic pclk,
	input  wire logic line_in,
	output logic      line_out
);
	// a real far end idles high between characters
	initial line_out = 1'b1;

	task automatic send(input logic [11:0] v, input int len);
		for (int i = 0; i < len; i++) begin
			line_out <= v[i];
			repeat (BC) @(posedge pclk);
		end
		line_out <= 1'b1;
	endtask

	// samples each slot near mid-bit; the start-edge wait is bounded so a dead line cannot hang
	task automatic catch_frame(input int len, output logic [11:0] v);
		int t;
		v = '1;
		t = 0;
		while (line_in !== 1'b0 && t < 400) begin
			@(posedge pclk);
			t++;
		end
		repeat (BC / 2) @(posedge pclk);
		for (int i = 0; i < len; i++) begin
			v[i] = line_in;
			repeat (BC) @(posedge pclk);
		end
	endtask
endmodule

// *** test/uart_channel_bench.sv ***
`timescale 1ns/1ps
module uart_channel_bench;
	localparam int BC = 8;
	logic                        pclk;
	logic                        presetn;
	logic                        psel;
	logic                        penable;
	logic                        pwrite;
	logic [uart_pkg::ADDR_W-1:0] paddr;
	logic [31:0]                 pwdata;
	logic [31:0]                 prdata;
	logic                        pready;
	logic                        pslverr;
	logic                        serial_in_pin;
	logic                        serial_out_pin;
	logic                        tx_empty_cause;
	logic                        rx_full_cause;
	int                          error_cnt = 0;
	int                          compares = 0;
	int                          tx_causes = 0;
	int                          rx_causes = 0;
	logic [31:0]                 rd;
	logic                        err;
	logic [11:0]                 seen;

	uart_channel #(.BIT_CYCLES(BC)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
		.tx_empty_cause(tx_empty_cause), .rx_full_cause(rx_full_cause)
	);

	uart_remote #(.BC(BC)) remote (
		.pclk(pclk), .line_in(serial_out_pin), .line_out(serial_in_pin)
	);

	initial pclk = 1'b0;
	always #25 pclk = ~pclk;

	always @(posedge pclk) begin
		if (tx_empty_cause === 1'b1) tx_causes <= tx_causes + 1;
		if (rx_full_cause === 1'b1) rx_causes <= rx_causes + 1;
	end

	task automatic chk(input string name, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", name, e, s);
		end
	endtask

	// one idle cycle before each setup keeps a release and the next request in separate steps
	task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] wd);
		int t;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, wd};
		@(posedge pclk);
		penable <= 1'b1;
		t = 0;
		do begin
			@(posedge pclk);
			t++;
		end while (pready !== 1'b1 && t < 50);
		if (t >= 50) error_cnt++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [15:0] idx, input logic [7:0] wd);
		apb(1'b1, idx, wd);
	endtask

	task automatic rchk(input logic [15:0] idx, input logic [7:0] m, input logic [7:0] e,
			input string name);
		apb(1'b0, idx, 8'h00);
		chk(name, rd & {24'hFFFFFF, m}, {24'h0, e});
	endtask

	task automatic cfg(input logic [7:0] fm, input logic [7:0] ctl);
		wr(uart_pkg::IDX_CONTROL, 8'h00);
		wr(uart_pkg::IDX_FORMAT, fm);
		wr(uart_pkg::IDX_CONTROL, ctl);
	endtask

	function automatic int flen(input logic [7:0] fm);
		return 9 + fm[4] + fm[3] + fm[1];
	endfunction

	// stop bits and unused slots stay high
	function automatic logic [11:0] frame(input logic [7:0] d, input logic [7:0] fm);
		logic [11:0] v;
		logic        p;
		v = '1;
		v[0] = 1'b0;
		p = fm[2];
		for (int i = 0; i < 7 + fm[4]; i++) begin
			v[1 + i] = d[i];
			p = p ^ d[i];
		end
		if (fm[3]) v[8 + fm[4]] = p;
		return v;
	endfunction

	task automatic txrun(input logic [7:0] d, input logic [7:0] fm);
		fork
			remote.catch_frame(flen(fm), seen);
			begin
				wr(uart_pkg::IDX_TXDATA, d);
				repeat (2 * BC) @(posedge pclk);
				rchk(uart_pkg::IDX_STATUS, 8'hFF, 8'h05, "busy");
			end
		join
		chk("tx frame", {20'h0, seen}, {20'h0, frame(d, fm)});
	endtask

	// bad 1 flips the parity slot, bad 2 drops the first stop bit
	task automatic rx(input logic [7:0] d, input logic [7:0] fm, input int bad);
		logic [11:0] v;
		v = frame(d, fm);
		if (bad == 1) v[8 + fm[4]] = ~v[8 + fm[4]];
		if (bad == 2) v[8 + fm[4] + fm[3]] = 1'b0;
		remote.send(v, flen(fm));
		repeat (4) @(posedge pclk);
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge pclk);
		error_cnt++;
		results();
	end

	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		presetn = 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rchk(uart_pkg::IDX_STATUS, 8'hFF, 8'h01, "status rst");
		rchk(uart_pkg::IDX_TXDATA, 8'hFF, 8'h00, "txdata rst");
		rchk(uart_pkg::IDX_RXDATA, 8'hFF, 8'h00, "rxdata rst");
		rchk(uart_pkg::IDX_FORMAT, 8'hFF, 8'h00, "format rst");
		apb(1'b0, 16'h4105, 8'h00);
		chk("unmapped", {31'h0, err}, 32'h1);
		cfg(8'h18, 8'h01);
		txrun(8'hA5, 8'h18);
		repeat (BC + 4) @(posedge pclk);
		rchk(uart_pkg::IDX_STATUS, 8'hFF, 8'h81, "done set");
		chk("tx cause", tx_causes, 32'd1);
		wr(uart_pkg::IDX_STATUS, 8'h7F);
		rchk(uart_pkg::IDX_STATUS, 8'hFF, 8'h81, "zero kept");
		wr(uart_pkg::IDX_STATUS, 8'h80);
		rchk(uart_pkg::IDX_STATUS, 8'hFF, 8'h01, "done clr");
		cfg(8'h06, 8'h01);
		txrun(8'hFF, 8'h06);
		rchk(uart_pkg::IDX_TXDATA, 8'hFF, 8'hFF, "txdata back");
		chk("tx cause", tx_causes, 32'd2);
		repeat (2 * BC) @(posedge pclk);
		wr(uart_pkg::IDX_STATUS, 8'h80);
		cfg(8'h10, 8'h03);
		rx(8'h3C, 8'h10, 0);
		rchk(uart_pkg::IDX_STATUS, 8'hFF, 8'h03, "one held");
		chk("full cause", rx_causes, 32'd0);
		rx(8'hC3, 8'h10, 0);
		rchk(uart_pkg::IDX_STATUS, 8'hFF, 8'h0B, "two held");
		chk("full cause", rx_causes, 32'd1);
		rx(8'h5A, 8'h10, 0);
		rchk(uart_pkg::IDX_STATUS, 8'hFF, 8'h1B, "overrun");
		rchk(uart_pkg::IDX_RXDATA, 8'hFF, 8'h3C, "oldest");
		rchk(uart_pkg::IDX_STATUS, 8'hFF, 8'h13, "second clr");
		rchk(uart_pkg::IDX_RXDATA, 8'hFF, 8'hC3, "kept");
		rchk(uart_pkg::IDX_STATUS, 8'hFF, 8'h11, "ready clr");
		wr(uart_pkg::IDX_STATUS, 8'h10);
		rchk(uart_pkg::IDX_STATUS, 8'hFF, 8'h01, "ovr clr");
		// 7-bit, odd parity, two stops: the parity slot exists for the error case
		cfg(8'h0E, 8'h01);
		rx(8'hD5, 8'h0E, 0);
		chk("full cause", rx_causes, 32'd2);
		rchk(uart_pkg::IDX_RXDATA, 8'hFF, 8'h55, "bit7 zero");
		rx(8'h2B, 8'h0E, 1);
		rchk(uart_pkg::IDX_STATUS, 8'hFF, 8'h23, "parity");
		rx(8'h4E, 8'h0E, 2);
		rchk(uart_pkg::IDX_STATUS, 8'h40, 8'h40, "framing");
		wr(uart_pkg::IDX_STATUS, 8'h60);
		rchk(uart_pkg::IDX_STATUS, 8'h60, 8'h00, "err clr");
		results();
	end
endmodule
